// >>> core/cisc_pkg.sv
// package: constants and types for the interrupt entry and stacking unit
package cisc_pkg;
    localparam int CISC_CCW_W = 16;                  // condition code word width
    localparam int CISC_LVL_W = 3;                   // priority level width
    localparam int CISC_FRAME_BYTES = 10;            // bytes pushed on entry
    localparam int CISC_IDX_W = 4;                   // frame byte index width
    // condition code word bit positions
    localparam int CISC_BIT_C = 0;
    localparam int CISC_BIT_V = 1;
    localparam int CISC_BIT_Z = 2;
    localparam int CISC_BIT_N = 3;
    localparam int CISC_BIT_I = 4;                   // global interrupt mask
    localparam int CISC_BIT_H = 5;
    localparam int CISC_BIT_X = 6;
    localparam int CISC_BIT_S = 7;
    localparam int CISC_LVL_LSB = 8;                 // prior_priority_level [10:8]
    localparam int CISC_BIT_U = 15;                  // user state flag
    // value after reset: stop, xirq mask and interrupt mask set, level 0
    localparam logic [15:0] CISC_CCW_RESET = 16'h00D0;
    // level code that turns a source off
    localparam logic [2:0] CISC_LVL_OFF = 3'h0;
    // frame layout, byte offsets above the final stack pointer
    localparam logic [3:0] CISC_OFS_CCW_LO = 4'h0;
    localparam logic [3:0] CISC_OFS_CCW_HI = 4'h1;
    localparam logic [3:0] CISC_OFS_B = 4'h2;
    localparam logic [3:0] CISC_OFS_A = 4'h3;
    localparam logic [3:0] CISC_OFS_X_HI = 4'h4;
    localparam logic [3:0] CISC_OFS_X_LO = 4'h5;
    localparam logic [3:0] CISC_OFS_Y_HI = 4'h6;
    localparam logic [3:0] CISC_OFS_Y_LO = 4'h7;
    localparam logic [3:0] CISC_OFS_PC_HI = 4'h8;
    localparam logic [3:0] CISC_OFS_PC_LO = 4'h9;
    localparam logic [3:0] CISC_IDX_LAST = 4'h9;
    localparam logic [15:0] CISC_FRAME_SIZE = 16'h000A;
    // sequencer states
    typedef enum logic [1:0] {
        CISC_IDLE = 2'b00,
        CISC_PUSH = 2'b01,
        CISC_POP  = 2'b10
    } cisc_state_e;
endpackage

// >>> core/cisc_arb_if.sv
// interface: winner of the priority arbitration passed to the core
interface cisc_arb_if #(parameter int SRC_N = 16, parameter int ID_W = 4);
    logic cpu_valid;              // an eligible request for the main cpu exists
    logic [ID_W-1:0] cpu_id;      // its source number
    logic [2:0] cpu_level;        // its level
    logic copro_valid;            // an eligible request for the coprocessor exists
    logic [ID_W-1:0] copro_id;    // its source number
    modport arb (output cpu_valid, cpu_id, cpu_level, copro_valid, copro_id);
    modport core (input cpu_valid, cpu_id, cpu_level, copro_valid, copro_id);
endinterface

// >>> core/cisc_arbiter.sv
// module: picks the highest level request for each destination
module cisc_arbiter
    import cisc_pkg::*;
#(
    parameter int SRC_N = 16,
    parameter int ID_W = 4
) (
    input wire logic [SRC_N-1:0] src_req,
    input wire logic [SRC_N*3-1:0] src_level,
    input wire logic [SRC_N-1:0] src_to_copro,
    cisc_arb_if.arb win
);
    // linear scan; higher level wins, lower source number breaks ties
    always_comb begin
        logic [2:0] best_cpu;
        logic [2:0] best_cop;
        logic [2:0] lv;
        best_cpu = CISC_LVL_OFF;
        best_cop = CISC_LVL_OFF;
        lv = CISC_LVL_OFF;
        win.cpu_valid = 1'b0;
        win.cpu_id = '0;
        win.cpu_level = CISC_LVL_OFF;
        win.copro_valid = 1'b0;
        win.copro_id = '0;
        for (int i = 0; i < SRC_N; i++) begin
            lv = src_level[i*3 +: 3];
            // level code zero disables the source; levels may change any time, see RULE_08
            if (src_req[i] && lv != CISC_LVL_OFF) begin
                if (src_to_copro[i]) begin // steered away from the cpu, see RULE_07
                    if (lv > best_cop) begin
                        best_cop = lv;
                        win.copro_valid = 1'b1;
                        win.copro_id = ID_W'(i);
                    end
                end else if (lv > best_cpu) begin
                    best_cpu = lv;
                    win.cpu_valid = 1'b1;
                    win.cpu_id = ID_W'(i);
                    win.cpu_level = lv;
                end
            end
        end
    end
endmodule // cisc_arbiter

// >>> core/cisc_core.sv
// module: interrupt entry, ten byte stacking and the 16-bit condition code word
// Operation
// RULE_01: condition code word is sixteen bits wide
// RULE_02: three-bit prior level field in upper byte
// RULE_03: entry loads level field with serviced level
// RULE_04: user flag set blocks privileged opcodes
// RULE_05: entry pushes a ten byte frame
// RULE_06: software offsets stack accesses one extra byte
// RULE_07: sources can be steered to the coprocessor
// RULE_08: seven levels per source, eighth disables
// RULE_09: accept only enabled, unmasked, higher level requests
// RULE_10: entry sets the global interrupt mask
// RULE_11: return restores full two-byte word from stack
module cisc_core
    import cisc_pkg::*;
#(
    parameter int SRC_N = 16,     // number of interrupt sources
    parameter int ID_W = 4        // width of a source number
) (
    input wire logic clk,
    input wire logic reset,
    // interrupt sources and their configuration
    input wire logic [SRC_N-1:0] src_req,
    input wire logic [SRC_N*3-1:0] src_level,
    input wire logic [SRC_N-1:0] src_to_copro,
    // coprocessor request handshake
    output logic copro_req,
    output logic [ID_W-1:0] copro_id,
    input wire logic copro_ack,
    // cpu sequencing
    input wire logic at_boundary,
    input wire logic rti_req,
    input wire logic [15:0] sp_in,
    input wire logic [15:0] pc_in,
    input wire logic [15:0] x_in,
    input wire logic [15:0] y_in,
    input wire logic [15:0] d_in,
    input wire logic ccw_wr,
    input wire logic [15:0] ccw_wdata,
    input wire logic priv_op,
    output logic priv_fault,
    output logic [15:0] condition_code_word,
    output logic busy,
    output logic entry_done,
    output logic [ID_W-1:0] entry_id,
    output logic rti_done,
    output logic [15:0] sp_out,
    output logic [15:0] rest_pc,
    output logic [15:0] rest_x,
    output logic [15:0] rest_y,
    output logic [15:0] rest_d,
    // stack memory byte port
    output logic mem_req,
    output logic mem_we,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic mem_ready,
    input wire logic [7:0] mem_rdata
);
    cisc_arb_if #(.SRC_N(SRC_N), .ID_W(ID_W)) win (); // arbitration result

    // priority pick over all sources
    cisc_arbiter #(.SRC_N(SRC_N), .ID_W(ID_W)) u_arb (
        .src_req(src_req),
        .src_level(src_level),
        .src_to_copro(src_to_copro),
        .win(win)
    );

    cisc_state_e state;                    // sequencer state
    cisc_state_e next_state;
    logic [15:0] ccw;                      // the condition code word, see RULE_01
    logic [15:0] next_ccw;
    logic [3:0] idx;                       // frame byte being moved
    logic [3:0] next_idx;
    logic [15:0] base;                     // lowest frame address
    logic [15:0] next_base;
    logic [7:0] frame [CISC_FRAME_BYTES];  // staged frame bytes
    logic [7:0] next_frame [CISC_FRAME_BYTES];
    logic [2:0] pend_lvl;                  // level being entered
    logic [2:0] next_pend_lvl;
    logic [ID_W-1:0] pend_id;              // source being entered
    logic [ID_W-1:0] next_pend_id;
    logic entry_q;                         // entry finished pulse
    logic next_entry_q;
    logic rti_q;                           // return finished pulse
    logic next_rti_q;
    logic [ID_W-1:0] entry_id_q;
    logic [ID_W-1:0] next_entry_id_q;
    logic cop_q;                           // coprocessor request held
    logic next_cop_q;
    logic [ID_W-1:0] cop_id_q;
    logic [ID_W-1:0] next_cop_id_q;
    logic take;                            // accept an interrupt now
    logic [15:0] ccw_merged;               // software write filtered by state

    // acceptance: enabled request, mask clear, level above the working level
    assign take = at_boundary && win.cpu_valid && !ccw[CISC_BIT_I]
                  && (win.cpu_level > ccw[CISC_LVL_LSB +: 3]); // see RULE_09

    // in user state the mask, level and user flag cannot be written
    always_comb begin
        ccw_merged = ccw_wdata;
        if (ccw[CISC_BIT_U]) begin // see RULE_04
            ccw_merged[CISC_BIT_I] = ccw[CISC_BIT_I];
            ccw_merged[CISC_LVL_LSB +: 3] = ccw[CISC_LVL_LSB +: 3];
            ccw_merged[CISC_BIT_U] = ccw[CISC_BIT_U];
            ccw_merged[14:11] = ccw[14:11];
        end
    end

    // privileged opcodes are refused while the user flag is set
    assign priv_fault = priv_op && ccw[CISC_BIT_U]; // see RULE_04

    // sequencer next state: idle, push ten bytes, or pop ten bytes
    always_comb begin
        next_state = state;
        next_ccw = ccw;
        next_idx = idx;
        next_base = base;
        next_frame = frame;
        next_pend_lvl = pend_lvl;
        next_pend_id = pend_id;
        next_entry_q = 1'b0;
        next_rti_q = 1'b0;
        next_entry_id_q = entry_id_q;
        case (state)
            CISC_IDLE: begin
                if (take) begin
                    // capture context; the stacked word holds the level before entry
                    next_frame[CISC_OFS_CCW_LO] = ccw[7:0];
                    next_frame[CISC_OFS_CCW_HI] = ccw[15:8]; // see RULE_02
                    next_frame[CISC_OFS_B] = d_in[7:0];
                    next_frame[CISC_OFS_A] = d_in[15:8];
                    next_frame[CISC_OFS_X_HI] = x_in[15:8];
                    next_frame[CISC_OFS_X_LO] = x_in[7:0];
                    next_frame[CISC_OFS_Y_HI] = y_in[15:8];
                    next_frame[CISC_OFS_Y_LO] = y_in[7:0];
                    next_frame[CISC_OFS_PC_HI] = pc_in[15:8];
                    next_frame[CISC_OFS_PC_LO] = pc_in[7:0];
                    next_base = sp_in - CISC_FRAME_SIZE; // ten byte frame, see RULE_05
                    next_idx = CISC_IDX_LAST;
                    next_pend_lvl = win.cpu_level;
                    next_pend_id = win.cpu_id;
                    next_state = CISC_PUSH;
                end else if (rti_req) begin
                    next_base = sp_in;
                    next_idx = 4'h0;
                    next_state = CISC_POP;
                end else if (ccw_wr) begin
                    next_ccw = ccw_merged;
                end
            end
            CISC_PUSH: begin
                // highest address first, so the word lands at the stack top
                if (mem_ready) begin
                    if (idx == 4'h0) begin
                        next_ccw[CISC_BIT_I] = 1'b1;                 // see RULE_10
                        next_ccw[CISC_LVL_LSB +: 3] = pend_lvl;      // see RULE_03
                        next_ccw[CISC_BIT_U] = 1'b0;                 // handler runs privileged
                        next_entry_q = 1'b1;
                        next_entry_id_q = pend_id;
                        next_state = CISC_IDLE;
                    end else begin
                        next_idx = idx - 4'h1;
                    end
                end
            end
            CISC_POP: begin
                // lowest address first; the word is the first two bytes read
                if (mem_ready) begin
                    next_frame[idx] = mem_rdata;
                    if (idx == CISC_IDX_LAST) begin
                        // whole two-byte word comes back, level and user flag included
                        next_ccw = {frame[CISC_OFS_CCW_HI], frame[CISC_OFS_CCW_LO]}; // see RULE_11
                        next_rti_q = 1'b1;
                        next_state = CISC_IDLE;
                    end else begin
                        next_idx = idx + 4'h1;
                    end
                end
            end
            default: next_state = CISC_IDLE;
        endcase
    end

    // sequencer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= CISC_IDLE;
            ccw <= CISC_CCW_RESET;
            idx <= 4'h0;
            base <= 16'h0000;
            for (int i = 0; i < CISC_FRAME_BYTES; i++) begin
                frame[i] <= 8'h00;
            end
            pend_lvl <= CISC_LVL_OFF;
            pend_id <= '0;
            entry_q <= 1'b0;
            rti_q <= 1'b0;
            entry_id_q <= '0;
        end else begin
            state <= next_state;
            ccw <= next_ccw;
            idx <= next_idx;
            base <= next_base;
            frame <= next_frame;
            pend_lvl <= next_pend_lvl;
            pend_id <= next_pend_id;
            entry_q <= next_entry_q;
            rti_q <= next_rti_q;
            entry_id_q <= next_entry_id_q;
        end
    end

    // coprocessor request: held until acknowledged so the id stays stable
    always_comb begin
        next_cop_q = cop_q;
        next_cop_id_q = cop_id_q;
        if (cop_q) begin
            if (copro_ack) begin
                next_cop_q = 1'b0;
            end
        end else if (win.copro_valid) begin // see RULE_07
            next_cop_q = 1'b1;
            next_cop_id_q = win.copro_id;
        end
    end

    // coprocessor request registers
    always_ff @(posedge clk) begin
        if (reset) begin
            cop_q <= 1'b0;
            cop_id_q <= '0;
        end else begin
            cop_q <= next_cop_q;
            cop_id_q <= next_cop_id_q;
        end
    end

    // memory port: one byte per accepted cycle
    assign mem_req = (state != CISC_IDLE);
    assign mem_we = (state == CISC_PUSH);
    assign mem_addr = base + {12'h000, idx};
    assign mem_wdata = frame[idx];

    // outputs; sp_out is the frame base after entry, base plus ten in the rti_done cycle only
    assign condition_code_word = ccw;
    assign busy = (state != CISC_IDLE);
    assign entry_done = entry_q;
    assign entry_id = entry_id_q;
    assign rti_done = rti_q;
    assign sp_out = rti_q ? (base + CISC_FRAME_SIZE) : base;
    assign rest_pc = {frame[CISC_OFS_PC_HI], frame[CISC_OFS_PC_LO]};
    assign rest_x = {frame[CISC_OFS_X_HI], frame[CISC_OFS_X_LO]};
    assign rest_y = {frame[CISC_OFS_Y_HI], frame[CISC_OFS_Y_LO]};
    assign rest_d = {frame[CISC_OFS_A], frame[CISC_OFS_B]};
    assign copro_req = cop_q;
    assign copro_id = cop_id_q;
endmodule // cisc_core

// >>> test/cisc_core_chk.sv
// checker: port relations of the interrupt stacking unit
module cisc_core_chk
    import cisc_pkg::*;
#(parameter int SRC_N = 16, parameter int ID_W = 4) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rti_req,
    input wire logic [15:0] sp_in,
    input wire logic priv_op,
    input wire logic priv_fault,
    input wire logic [15:0] condition_code_word,
    input wire logic busy,
    input wire logic entry_done,
    input wire logic rti_done,
    input wire logic [15:0] sp_out,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_ready,
    input wire logic copro_req,
    input wire logic [ID_W-1:0] copro_id,
    input wire logic copro_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt; // bytes moved in this push or pop
    logic [7:0] last_b; // newest byte written
    logic [7:0] prev_b; // byte before it, the stacked word high byte
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // count handshakes; cleared while idle so each frame starts from zero
    always_ff @(posedge clk) begin
        if (reset || !busy) cnt <= 4'h0;
        else if (mem_req && mem_ready) cnt <= cnt + 4'h1;
        if (mem_req && mem_we && mem_ready) begin
            prev_b <= last_b;
            last_b <= mem_wdata;
        end
    end
    // first cycle of a push
    sequence push_start;
        !busy ##1 (busy && mem_we);
    endsequence
    reset_word_a: assert property ($fell(reset) |-> condition_code_word == CISC_CCW_RESET)
        else $error("word not at reset value");
    priv_block_a: assert property (priv_fault == (priv_op && condition_code_word[15]))
        else $error("privileged fault wrong");
    push_len_a: assert property (entry_done |-> cnt == 4'hA)
        else $error("push length wrong");
    pop_len_a: assert property (rti_done |-> cnt == 4'hA)
        else $error("pop length wrong");
    first_addr_a: assert property (push_start |-> mem_addr == $past(sp_in) - 16'h1)
        else $error("first push address wrong");
    entry_sp_a: assert property (entry_done |-> sp_out == $past(mem_addr))
        else $error("stack pointer after entry wrong");
    rti_sp_a: assert property (rti_done |-> sp_out == $past(mem_addr) + 16'h1)
        else $error("stack pointer after return wrong");
    entry_mask_a: assert property (entry_done |-> condition_code_word[4] && !condition_code_word[15])
        else $error("mask not set on entry");
    level_raise_a: assert property (entry_done |-> prev_b[2:0] < condition_code_word[10:8])
        else $error("level not raised");
    masked_idle_a: assert property (!busy && condition_code_word[4] && !rti_req |=> !(busy && mem_we))
        else $error("entry while masked");
    copro_hold_a: assert property (copro_req && !copro_ack |=> copro_req && $stable(copro_id))
        else $error("coprocessor request dropped");
    copro_drop_a: assert property (copro_req && copro_ack |=> !copro_req)
        else $error("coprocessor request not cleared");
endmodule // cisc_core_chk
bind cisc_core cisc_core_chk #(.SRC_N(SRC_N), .ID_W(ID_W)) i_chk (
    .clk(clk), .reset(reset), .rti_req(rti_req), .sp_in(sp_in), .priv_op(priv_op),
    .priv_fault(priv_fault), .condition_code_word(condition_code_word), .busy(busy),
    .entry_done(entry_done), .rti_done(rti_done), .sp_out(sp_out), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
    .copro_req(copro_req), .copro_id(copro_id), .copro_ack(copro_ack)
);

// >>> test/cisc_partner.sv
// partner: stack memory and coprocessor acknowledge
module cisc_partner (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic mem_ready,
    output logic [7:0] mem_rdata,
    input wire logic copro_req,
    output logic copro_ack
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [0:65535]; // byte stack memory
    logic [1:0] tick; // pacing for stalls
    logic [7:0] last; // last value on the data line
    initial begin
        mem_ready = 1'b0;
        mem_rdata = 8'h00;
        copro_ack = 1'b0;
        tick = 2'h0;
        last = 8'h00;
    end
    // answer off the sampling edge; a slow memory accepts one byte in four
    always @(negedge clk) begin
        tick = tick + 2'h1;
        mem_ready = !reset && mem_req && (!slow || tick == 2'h3);
        // undriven data toggles so a stale byte can never pass
        last = (mem_ready && !mem_we) ? mem[mem_addr] : ~last;
        mem_rdata = last;
        copro_ack = copro_req && tick[0];
    end
    always @(posedge clk) begin
        if (mem_req && mem_we && mem_ready) mem[mem_addr] <= mem_wdata;
    end
endmodule // cisc_partner

// >>> test/cisc_core_tb.sv
// testbench: random and corner runs of the interrupt stacking unit
module cisc_core_tb
    import cisc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, reset, copro_req, copro_ack, at_boundary, rti_req, ccw_wr, priv_op, priv_fault;
    logic busy, entry_done, rti_done, mem_req, mem_we, mem_ready, slow, saw_busy, saw_cop;
    logic [15:0] src_req, src_to_copro, sp_in, pc_in, x_in, y_in, d_in, ccw_wdata, word;
    logic [15:0] sp_out, rest_pc, rest_x, rest_y, rest_d, mem_addr;
    logic [47:0] src_level;
    logic [3:0] copro_id, entry_id, cop_id;
    logic [7:0] mem_wdata, mem_rdata;
    int failures, num_checks, seed, lv;
    cisc_core i_dut (
        .clk(clk), .reset(reset), .src_req(src_req), .src_level(src_level),
        .src_to_copro(src_to_copro), .copro_req(copro_req), .copro_id(copro_id),
        .copro_ack(copro_ack), .at_boundary(at_boundary), .rti_req(rti_req), .sp_in(sp_in),
        .pc_in(pc_in), .x_in(x_in), .y_in(y_in), .d_in(d_in), .ccw_wr(ccw_wr),
        .ccw_wdata(ccw_wdata), .priv_op(priv_op), .priv_fault(priv_fault),
        .condition_code_word(word), .busy(busy), .entry_done(entry_done),
        .entry_id(entry_id), .rti_done(rti_done), .sp_out(sp_out), .rest_pc(rest_pc),
        .rest_x(rest_x), .rest_y(rest_y), .rest_d(rest_d), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ready(mem_ready), .mem_rdata(mem_rdata)
    );
    cisc_partner i_mem (
        .clk(clk), .reset(reset), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .copro_req(copro_req), .copro_ack(copro_ack)
    );
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // watch for any stacking or coprocessor request
    always @(posedge clk) begin
        if (busy === 1'b1) saw_busy <= 1'b1;
        if (copro_req === 1'b1) begin
            saw_cop <= 1'b1;
            cop_id <= copro_id;
        end
    end
    task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr_ccw(input logic [15:0] w);
        ccw_wr = 1'b1;
        ccw_wdata = w;
        @(negedge clk);
        ccw_wr = 1'b0;
        @(negedge clk);
    endtask
    // bounded wait for the entry or return pulse
    task automatic wait_for(input bit rti);
        for (int i = 0; i < 200; i++) begin
            @(negedge clk);
            if ((rti ? rti_done : entry_done) === 1'b1) return;
        end
        chk("handshake", 16'h0, 16'h1);
    endtask
    // expected frame byte k: word and d low byte first, the rest high byte first
    function automatic logic [7:0] fb(input int k, input logic [15:0] w);
        logic [15:0] v;
        v = (k < 2) ? w : (k < 4) ? d_in : (k < 6) ? x_in : (k < 8) ? y_in : pc_in;
        return ((k < 4) == k[0]) ? v[15:8] : v[7:0];
    endfunction
    // one request stays pending without being taken by the cpu
    task automatic refuse(input logic [15:0] w, input logic [2:0] l, input bit cop);
        wr_ccw(w);
        src_level[8:6] = l;
        src_to_copro[2] = cop;
        src_req[2] = 1'b1;
        saw_busy = 1'b0;
        saw_cop = 1'b0;
        repeat (12) @(negedge clk);
        src_req[2] = 1'b0;
        chk("no entry", saw_busy, 16'h0);
        chk("copro", saw_cop, cop);
        if (cop) chk("copro id", cop_id, 16'h2);
        repeat (6) @(negedge clk);
        src_to_copro[2] = 1'b0;
        $display("refusal case done");
    endtask
    // entry from word w at level l, frame check, then return
    task automatic round(input int s, input logic [15:0] w, input logic [2:0] l);
        logic [15:0] sp;
        sp = 16'($random(seed));
        pc_in = 16'($random(seed));
        x_in = 16'($random(seed));
        y_in = 16'($random(seed));
        d_in = 16'($random(seed));
        wr_ccw(w);
        chk("word", word, w);
        chk("user", priv_fault, w[15]);
        // user state guards mask, level, user flag and spare bits; no fault without an opcode
        if (w[15]) begin
            priv_op = 1'b0;
            wr_ccw(16'h7F10);
            chk("user write", word, {w[15:8], 8'h00});
            chk("no fault", priv_fault, 16'h0);
            priv_op = 1'b1;
            wr_ccw(w);
            chk("user fault", priv_fault, 16'h1);
        end
        sp_in = sp;
        src_level[3*s +: 3] = l;
        src_req[s] = 1'b1;
        wait_for(1'b0);
        src_req[s] = 1'b0;
        chk("id", entry_id, 16'(s));
        chk("entry", {priv_fault, word[15], word[10:8], word[4]}, {2'b00, l, 1'b1});
        chk("sp", sp_out, sp - 16'hA);
        for (int k = 0; k < 10; k++) begin
            chk("frame", i_mem.mem[sp - 16'hA + 16'(k)], fb(k, w));
        end
        sp_in = sp - 16'hA;
        rti_req = 1'b1;
        @(negedge clk);
        rti_req = 1'b0;
        wait_for(1'b1);
        chk("regs", rest_pc ^ rest_x ^ rest_y ^ rest_d, pc_in ^ x_in ^ y_in ^ d_in);
        chk("pc", rest_pc, pc_in);
        chk("d", rest_d, d_in);
        chk("x", rest_x, x_in);
        chk("y", rest_y, y_in);
        chk("word back", word, w);
        chk("sp back", sp_out, sp);
        chk("user back", priv_fault, w[15]);
        $display("round done");
    endtask
    // stop a hang: the whole run needs well under a thousand cycles
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        seed = 32'h7915;
        failures = 0;
        num_checks = 0;
        {reset, priv_op, at_boundary} = 3'b111;
        {slow, rti_req, ccw_wr, saw_busy, saw_cop} = 5'h0;
        {src_req, src_to_copro, ccw_wdata, sp_in} = 64'h0;
        {pc_in, x_in, y_in, d_in} = 64'h0;
        src_level = {16'($random(seed)), $random(seed)};
        repeat (10) @(negedge clk);
        reset = 1'b0;
        chk("reset word", word, CISC_CCW_RESET);
        refuse(16'h00C0, 3'h0, 1'b0);
        refuse(16'h00D0, 3'h6, 1'b0);
        refuse(16'h04C0, 3'h4, 1'b0);
        refuse(16'h00C0, 3'h5, 1'b1);
        // last round runs in user state
        for (int i = 0; i < 8; i++) begin
            lv = {$random(seed)} % 7;
            slow = i[0];
            round({$random(seed)} % 16, {i == 7, 4'h0, 3'(lv), 8'hC0 | (8'h2F & 8'($random(seed)))},
                3'(lv + 1 + {$random(seed)} % (7 - lv)));
        end
        wrap_up();
    end
endmodule // cisc_core_tb
